// [exec_unit.sv]
// Execution unit for the bit, compare, divide, stack, table and shift operations.
`timescale 1ns/1ps
// Contract
// - Test then set records bit, sets it
// - Returns take three or two cycles
// - Power save picks sleep or idle, flags
// - Interrupt hold lasts literal instruction cycles
// - Divide variants, eighteen cycles, four flags
// - Register compare skips on equal/greater/less/unequal
// - Compare with borrow updates five flags
// - Bit scans write position, carry only
// - Multiply writes product to register pair
// - Double move takes two cycles
// - Pair push/pop two cycles, single one
// - Repeat next instruction count plus one
// - Sign extend updates carry, negative, zero
// - Table read high byte or low word
// - Table write high byte or low word
// - Decimal adjust updates carry only
// - Rotates through carry update carry too
// - Multi-bit shifts skip carry and overflow
// - Literal move, word or byte
// - Zero top byte executes as no-operation
// - Taken skip costs two or three cycles
module exec_unit #(
   parameter int STACK_DEPTH = 16
) (
   // Clock, reset and enable.
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   // Operation request and completion.
   input  wire logic             req_valid,
   input  wire exec_pkg::req_t   req,
   output logic                  ready_r,
   output logic                  done_r,
   output logic                  skip_r,
   // Status and core control.
   output exec_pkg::flags_t      flags_r,
   output logic                  irq_hold_r,
   output logic                  sleep_r,
   output logic                  idle_r,
   output logic                  watchdog_timeout_flag_r,
   output logic                  sleep_flag_r,
   input  wire logic             wake,
   output logic                  rep_load_r,
   output logic [13:0]           rep_cnt_r,
   output logic [15:0]           ret_addr_r,
   // Program memory.
   output exec_pkg::pm_req_t     pm_r,
   input  wire logic [23:0]      pm_rdata,
   // Register observation.
   input  wire logic [3:0]       obs_sel,
   output logic [15:0]           obs_r
);
   import exec_pkg::*;
   localparam int SPW = $clog2(STACK_DEPTH);

   // ****************************************************
   // Helper functions
   // ****************************************************
   // Scans a word; returns carry (nothing found) above the position.
   function automatic logic [16:0] scan(input logic [1:0] m, input logic [15:0] v);
      logic [16:0] r;
      r = {1'b1, 16'h0000};
      for (int i = 15; i >= 0; i--) begin
         if (m == 2'd0 && v[i]) begin
            r = {1'b0, 16'(i + 1)};
         end
      end
      for (int i = 0; i < 16; i++) begin
         if (m == 2'd1 && v[i]) begin
            r = {1'b0, 16'(16 - i)};
         end
         if (m == 2'd2 && i < 15 && v[i] != v[15]) begin
            r = {1'b0, 16'(i - 14)};
         end
      end
      return r;
   endfunction

   // Zero test used by several flag updates.
   function automatic logic is_zero(input logic [15:0] v);
      return v == 16'h0000;
   endfunction

   // ****************************************************
   // State
   // ****************************************************
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} st_t;
   st_t               st_r, st_nxt;            // Idle or counting extra cycles.
   logic [4:0]        cnt_r, cnt_nxt;          // Extra cycles still to run.
   req_t              cur_r, cur_nxt;          // Operation in flight.
   logic [15:0]       rf_r [16];               // Working registers.
   logic [15:0]       rf_nxt [16];
   logic [15:0]       stk_r [STACK_DEPTH];     // Software stack.
   logic [15:0]       stk_nxt [STACK_DEPTH];
   logic [SPW-1:0]    sp_r, sp_nxt;            // Stack pointer.
   logic [13:0]       hold_r, hold_nxt;        // Interrupt hold counter.
   flags_t            fl_nxt;
   logic              ready_nxt, done_nxt, skip_nxt, sleep_nxt, idle_nxt;
   logic              watchdog_timeout_flag_nxt, slf_nxt, rep_ld_nxt;
   logic [13:0]       rep_nxt;
   logic [15:0]       ret_nxt;
   pm_req_t           pm_nxt;
   logic [4:0]        cyc;                     // Cycle count of the new operation.
   logic              acc;                     // Request taken this cycle.
   logic              sel_bit;                 // Bit chosen by a bit test.

   assign acc = ce && st_r == ST_IDLE && req_valid;
   assign sel_bit = rf_r[req.ra][req.use_lit ? req.lit[3:0] : rf_r[req.rb][3:0]];

   // ****************************************************
   // Next-state computation
   // ****************************************************
   // Executes the taken operation and runs out its cycle count.
   always_comb begin
      logic [15:0] a, b, r, a1;
      logic [3:0]  bs;
      logic [16:0] d17, sc;
      logic [4:0]  d5;
      logic [4:0]  amt;
      logic        tk;
      logic signed [33:0] p;
      logic signed [32:0] dvd, q, rm;
      logic signed [16:0] dvs;
      a = rf_r[req.ra];
      a1 = rf_r[4'(req.ra + 4'h1)];
      b = req.use_lit ? req.lit : rf_r[req.rb];
      bs = b[3:0];
      r = 16'h0000; d17 = '0; sc = '0; d5 = '0; amt = 5'd1; tk = 1'b0;
      p = '0; dvd = '0; q = '0; rm = '0; dvs = '0;
      st_nxt = st_r; cnt_nxt = cnt_r; cur_nxt = cur_r;
      rf_nxt = rf_r; stk_nxt = stk_r; sp_nxt = sp_r;
      fl_nxt = flags_r; cyc = 5'd1;
      done_nxt = 1'b0; skip_nxt = 1'b0; rep_ld_nxt = 1'b0; pm_nxt = '0;
      rep_nxt = rep_cnt_r; ret_nxt = ret_addr_r;
      watchdog_timeout_flag_nxt = watchdog_timeout_flag_r; slf_nxt = sleep_flag_r;
      sleep_nxt = sleep_r && !wake;
      idle_nxt = idle_r && !wake;
      hold_nxt = (hold_r != 14'h0000) ? 14'(hold_r - 14'h0001) : hold_r;
      unique case (st_r)
         ST_IDLE: begin
            if (req_valid) begin
               cur_nxt = req;
               // An orphan second word only passes time.
               if (req.word_msb != NOP_MSBS) begin
                  unique case (req.op)
                     OP_BIT_TEST_OP, OP_BIT_TEST_THEN_SET_OP: begin
                        // Only the chosen flag moves; others stay.
                        if (req.alt) fl_nxt.z = ~sel_bit;
                        else fl_nxt.c = sel_bit;
                        if (req.op == OP_BIT_TEST_THEN_SET_OP) rf_nxt[req.ra][bs] = 1'b1;
                     end
                     OP_RET: begin
                        // Return address comes off the stack.
                        cyc = 5'(req.short_ret ? RET_SHORT : RET_CYCLES);
                        sp_nxt = SPW'(sp_r - 1'b1);
                        ret_nxt = stk_r[SPW'(sp_r - 1'b1)];
                        if (req.alt) rf_nxt[req.rd] = req.lit;
                     end
                     OP_POWER_SAVE_OP: begin
                        // Literal one selects idle, zero selects sleep.
                        if (req.lit[0]) idle_nxt = 1'b1;
                        else begin
                           sleep_nxt = 1'b1;
                           slf_nxt = 1'b1;
                        end
                        watchdog_timeout_flag_nxt = 1'b0;
                     end
                     OP_HOLD: hold_nxt = req.lit[13:0];
                     OP_DIV: begin
                        // Quotient to register 0, remainder to register 1.
                        cyc = 5'(DIV_CYCLES);
                        if (req.alt) dvd = req.mode[0] ? 33'(signed'({a1, a})) : 33'({a1, a});
                        else dvd = req.mode[0] ? 33'(signed'(a)) : 33'(a);
                        dvs = req.mode[0] ? 17'(signed'(rf_r[req.rb])) : 17'(rf_r[req.rb]);
                        if (dvs != 17'sd0) begin
                           q = dvd / dvs;
                           rm = dvd % dvs;
                        end
                        rf_nxt[0] = q[15:0];
                        rf_nxt[1] = rm[15:0];
                        fl_nxt.n = q[15];
                        fl_nxt.z = is_zero(q[15:0]);
                        fl_nxt.c = !is_zero(rm[15:0]);
                        fl_nxt.ov = (dvs == 17'sd0) || (req.mode[0] ?
                                    (q > 33'sd32767 || q < -33'sd32768) : (q > 33'sd65535));
                     end
                     OP_CPSKIP: begin
                        // Signed compare; a taken skip stretches the count.
                        unique case (req.mode)
                           2'd0: tk = a == b;
                           2'd1: tk = $signed(a) > $signed(b);
                           2'd2: tk = $signed(a) < $signed(b);
                           default: tk = a != b;
                        endcase
                        skip_nxt = tk;
                        if (tk) cyc = 5'(req.two_next ? SKIP2_CYCLES : SKIP1_CYCLES);
                     end
                     OP_CPB: begin
                        // Result is dropped; zero only stays or clears.
                        d17 = 17'({1'b0, a} - {1'b0, b} - 17'(!flags_r.c));
                        d5 = 5'({1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(!flags_r.c));
                        fl_nxt.c = ~d17[16];
                        fl_nxt.dc = ~d5[4];
                        fl_nxt.n = d17[15];
                        fl_nxt.ov = (a[15] ^ b[15]) & (a[15] ^ d17[15]);
                        fl_nxt.z = flags_r.z & is_zero(d17[15:0]);
                     end
                     OP_SCAN: begin
                        sc = scan(req.mode, a);
                        rf_nxt[req.rd] = sc[15:0];
                        fl_nxt.c = sc[16];
                     end
                     OP_MUL: begin
                        // Short literal is zero extended.
                        p = $signed({req.mode[1] & a[15], a}) *
                            $signed({req.mode[0] & ~req.use_lit & b[15],
                                     req.use_lit ? {11'h000, req.lit[4:0]} : b});
                        rf_nxt[req.rd] = p[15:0];
                        rf_nxt[4'(req.rd + 4'h1)] = p[31:16];
                     end
                     OP_MOVD: begin
                        cyc = 5'(PAIR_CYCLES);
                        rf_nxt[req.rd] = a;
                        rf_nxt[4'(req.rd + 4'h1)] = a1;
                     end
                     OP_PUSH: begin
                        stk_nxt[sp_r] = a;
                        sp_nxt = SPW'(sp_r + 1'b1);
                        if (req.alt) begin
                           cyc = 5'(PAIR_CYCLES);
                           stk_nxt[SPW'(sp_r + 1'b1)] = a1;
                           sp_nxt = SPW'(sp_r + 2'd2);
                        end
                     end
                     OP_POP: begin
                        rf_nxt[req.rd] = stk_r[SPW'(sp_r - 1'b1)];
                        sp_nxt = SPW'(sp_r - 1'b1);
                        if (req.alt) begin
                           cyc = 5'(PAIR_CYCLES);
                           rf_nxt[req.rd] = stk_r[SPW'(sp_r - 2'd2)];
                           rf_nxt[4'(req.rd + 4'h1)] = stk_r[SPW'(sp_r - 1'b1)];
                           sp_nxt = SPW'(sp_r - 2'd2);
                        end
                     end
                     OP_REPEAT: begin
                        rep_ld_nxt = 1'b1;
                        rep_nxt = req.use_lit ? req.lit[13:0] : a[13:0];
                     end
                     OP_SEXT: begin
                        r = {{8{a[7]}}, a[7:0]};
                        rf_nxt[req.rd] = r;
                        fl_nxt.c = ~a[7];
                        fl_nxt.n = a[7];
                        fl_nxt.z = is_zero(r);
                     end
                     OP_TBLRD, OP_TBLWT: begin
                        // Data lands or leaves in the extra cycle.
                        cyc = 5'(PAIR_CYCLES);
                        pm_nxt.high = req.alt;
                        pm_nxt.rd_en = req.op == OP_TBLRD;
                        pm_nxt.wr_en = req.op == OP_TBLWT;
                        pm_nxt.addr = (req.op == OP_TBLRD) ? a : rf_r[req.rd];
                        pm_nxt.wdata = req.alt ? {a[7:0], 16'h0000} : {8'h00, a};
                     end
                     OP_BCD: begin
                        // Packed decimal fix-up of the low byte.
                        d17 = {9'h000, a[7:0]};
                        if (d17[3:0] > 4'h9 || flags_r.dc) d17 = 17'(d17 + 17'h00006);
                        if (d17[8:4] > 5'h09 || flags_r.c) d17 = 17'(d17 + 17'h00060);
                        rf_nxt[req.ra] = {a[15:8], d17[7:0]};
                        fl_nxt.c = flags_r.c | d17[8];
                     end
                     OP_ROT: begin
                        unique case (req.mode)
                           2'd0: r = {a[14:0], flags_r.c};
                           2'd1: r = {flags_r.c, a[15:1]};
                           2'd2: r = {a[14:0], a[15]};
                           default: r = {a[0], a[15:1]};
                        endcase
                        if (!req.mode[1]) fl_nxt.c = req.mode[0] ? a[0] : a[15];
                        rf_nxt[req.rd] = r;
                        fl_nxt.n = r[15];
                        fl_nxt.z = is_zero(r);
                     end
                     OP_SHIFT: begin
                        // Mode 0 left, 1 logical right, 2 arithmetic right.
                        if (req.alt) amt = req.use_lit ? req.lit[4:0] : rf_r[req.rb][4:0];
                        unique case (req.mode)
                           2'd0: r = 16'({16'h0000, a} << amt);
                           2'd1: r = 16'({16'h0000, a} >> amt);
                           default: r = 16'($signed({{16{a[15]}}, a}) >>> amt);
                        endcase
                        if (!req.alt) begin
                           fl_nxt.c = (req.mode == 2'd0) ? a[15] : a[0];
                           fl_nxt.ov = (req.mode == 2'd0) && (a[15] ^ a[14]);
                        end
                        rf_nxt[req.rd] = r;
                        fl_nxt.n = r[15];
                        fl_nxt.z = is_zero(r);
                     end
                     OP_MOVLIT: begin
                        if (req.byte_m) rf_nxt[req.rd][7:0] = req.lit[7:0];
                        else rf_nxt[req.rd] = req.lit;
                     end
                     default: ;
                  endcase
               end
               // Extra cycles idle the unit before the next request.
               if (cyc > 5'd1) begin
                  st_nxt = ST_BUSY;
                  cnt_nxt = 5'(cyc - 5'd2);
               end else begin
                  done_nxt = 1'b1;
               end
            end
         end
         ST_BUSY: begin
            if (cnt_r == 5'd0) begin
               st_nxt = ST_IDLE;
               done_nxt = 1'b1;
               if (cur_r.op == OP_TBLRD && cur_r.word_msb != NOP_MSBS) begin
                  if (cur_r.alt) rf_nxt[cur_r.rd][7:0] = pm_rdata[23:16];
                  else rf_nxt[cur_r.rd] = pm_rdata[15:0];
               end
            end else begin
               cnt_nxt = 5'(cnt_r - 5'd1);
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      ready_nxt = st_nxt == ST_IDLE;
   end

   // ****************************************************
   // Registers
   // ****************************************************
   // Holds all state; a low enable freezes everything.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= ST_IDLE; cnt_r <= '0; cur_r <= '0; sp_r <= '0; hold_r <= '0;
         for (int i = 0; i < 16; i++) rf_r[i] <= 16'h0000;
         for (int i = 0; i < STACK_DEPTH; i++) stk_r[i] <= 16'h0000;
         flags_r <= FLAGS_RST; ready_r <= 1'b1; done_r <= 1'b0; skip_r <= 1'b0;
         irq_hold_r <= 1'b0; sleep_r <= 1'b0; idle_r <= 1'b0; watchdog_timeout_flag_r <= 1'b0;
         sleep_flag_r <= 1'b0; rep_load_r <= 1'b0; rep_cnt_r <= '0;
         ret_addr_r <= '0; pm_r <= '0; obs_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt; cnt_r <= cnt_nxt; cur_r <= cur_nxt; sp_r <= sp_nxt;
         hold_r <= hold_nxt; rf_r <= rf_nxt; stk_r <= stk_nxt;
         flags_r <= fl_nxt; ready_r <= ready_nxt; done_r <= done_nxt;
         skip_r <= skip_nxt; irq_hold_r <= hold_nxt != 14'h0000;
         sleep_r <= sleep_nxt; idle_r <= idle_nxt; watchdog_timeout_flag_r <= watchdog_timeout_flag_nxt;
         sleep_flag_r <= slf_nxt; rep_load_r <= rep_ld_nxt; rep_cnt_r <= rep_nxt;
         ret_addr_r <= ret_nxt; pm_r <= pm_nxt; obs_r <= rf_nxt[obs_sel];
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   logic [4:0] meas_r;  // Cycles since the last taken request.
   logic [4:0] exp_r;   // Count that request must last.
   // Measures each operation from its take to its completion.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meas_r <= '0;
         exp_r <= '0;
      end else if (ce) begin
         meas_r <= acc ? 5'd1 : 5'(meas_r + 5'd1);
         if (acc) exp_r <= cyc;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn || !ce);
   property p_count; done_r |-> meas_r == exp_r; endproperty
   a_count: assert property (p_count) else $error("wrong cycle count");
   property p_div;
      acc && req.op == OP_DIV && req.word_msb != 8'h00 |=> (!ready_r)[*8] ##10 (ready_r && done_r);
   endproperty
   a_div: assert property (p_div) else $error("divide length wrong");
   property p_mul_keep;
      acc && req.op == OP_MUL |=> flags_r == $past(flags_r);
   endproperty
   a_mul_keep: assert property (p_mul_keep) else $error("multiply moved flags");
   property p_bts;
      acc && req.op == OP_BIT_TEST_THEN_SET_OP && req.use_lit && req.word_msb != 8'h00
         |=> rf_r[cur_r.ra][cur_r.lit[3:0]];
   endproperty
   a_bts: assert property (p_bts) else $error("test-then-set bit not set");
   property p_bit_test_op;
      acc && req.op == OP_BIT_TEST_OP && !req.alt && req.word_msb != 8'h00
         |=> flags_r.c == $past(sel_bit) && flags_r.z == $past(flags_r.z);
   endproperty
   a_bit_test_op: assert property (p_bit_test_op) else $error("bit test to carry wrong");
   property p_hold;
      acc && req.op == OP_HOLD && req.lit[13:0] > 14'd2 && req.word_msb != 8'h00
         |=> irq_hold_r[*2];
   endproperty
   a_hold: assert property (p_hold) else $error("interrupt hold not held");
   property p_sleep;
      acc && req.op == OP_POWER_SAVE_OP && !req.lit[0] && req.word_msb != 8'h00
         |=> sleep_r && sleep_flag_r && !watchdog_timeout_flag_r && !idle_r;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
   property p_skip;
      skip_r |-> (exp_r == 5'd2 || exp_r == 5'd3) ##[1:2] done_r;
   endproperty
   a_skip: assert property (p_skip) else $error("skip length wrong");
   c_div: cover property (acc && req.op == OP_DIV ##18 done_r);
   c_skip3: cover property (skip_r && exp_r == 5'd3);
   c_tblrd: cover property (pm_r.rd_en ##1 done_r);
endmodule

// [exec_pkg.sv]
// Shared types and constants of the instruction execution unit.
package exec_pkg;
   // ****************************************************
   // Cycle counts and reset values
   // ****************************************************
   localparam int unsigned DIV_CYCLES   = 18;  // Divide length.
   localparam int unsigned RET_CYCLES   = 3;   // Return, long case.
   localparam int unsigned RET_SHORT    = 2;   // Return, short case.
   localparam int unsigned PAIR_CYCLES  = 2;   // Double move, stack pair, table.
   localparam int unsigned SKIP1_CYCLES = 2;   // Skip over a one-word op.
   localparam int unsigned SKIP2_CYCLES = 3;   // Skip over a two-word op.
   localparam logic [7:0]  NOP_MSBS     = 8'h00; // Top byte of a second word.
   localparam logic [4:0]  FLAGS_RST    = 5'h00; // Flags after reset.

   // ****************************************************
   // Operations, requests and flags
   // ****************************************************
   typedef enum logic [4:0] {
      OP_NOP, OP_BIT_TEST_OP, OP_BIT_TEST_THEN_SET_OP, OP_RET, OP_POWER_SAVE_OP, OP_HOLD, OP_DIV,
      OP_CPSKIP, OP_CPB, OP_SCAN, OP_MUL, OP_MOVD, OP_PUSH, OP_POP,
      OP_REPEAT, OP_SEXT, OP_TBLRD, OP_TBLWT, OP_BCD, OP_ROT, OP_SHIFT,
      OP_MOVLIT
   } op_t;
   typedef struct packed {
      op_t         op;        // Operation.
      logic [1:0]  mode;      // Variant selector.
      logic        alt;       // Second variant bit.
      logic        byte_m;    // Byte mode.
      logic        use_lit;   // Literal replaces the second register.
      logic        two_next;  // Following instruction is two words.
      logic        short_ret; // Return takes its short form.
      logic [7:0]  word_msb;  // Top byte of the instruction word.
      logic [3:0]  ra;        // First source register.
      logic [3:0]  rb;        // Second source register.
      logic [3:0]  rd;        // Destination register.
      logic [15:0] lit;       // Literal operand.
   } req_t;
   typedef struct packed {
      logic c;
      logic dc;
      logic n;
      logic ov;
      logic z;
   } flags_t;
   typedef struct packed {
      logic        rd_en;  // Program memory read strobe.
      logic        wr_en;  // Program memory write strobe.
      logic        high;   // Upper byte lane selected.
      logic [15:0] addr;   // Program memory word address.
      logic [23:0] wdata;  // Write data.
   } pm_req_t;
endpackage

// [pm_model.sv]
// Program memory model that answers table reads and keeps table writes.
`timescale 1ns/1ps
module pm_model (
   input  wire logic              clk,
   input  wire exec_pkg::pm_req_t pm,
   output logic [23:0]            rdata
);
   import exec_pkg::*;
   logic [23:0] mem [16]; // Sixteen words of storage.
   // Data is valid only in the strobe cycle; otherwise the inverse shows.
   assign rdata = pm.rd_en ? mem[pm.addr[3:0]] : ~mem[pm.addr[3:0]];
   // A write lands in the selected lane only.
   always @(posedge clk) begin
      if (pm.wr_en && pm.high)
         mem[pm.addr[3:0]][23:16] <= pm.wdata[23:16];
      else if (pm.wr_en)
         mem[pm.addr[3:0]][15:0] <= pm.wdata[15:0];
   end
   initial foreach (mem[i]) mem[i] = 24'h000000;
endmodule

// [exec_unit_tb.sv]
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
module exec_unit_tb;
   import exec_pkg::*;
   typedef struct {int lat; int t0; logic [15:0] v; flags_t fm; flags_t fv;} note_t;
   logic        clk = 0, rstn = 0, req_valid = 0, ready_r, done_r;
   logic        skip_r, irq_hold_r, sleep_r; // Pulse and level outputs under test.
   req_t        req = '0, r;
   logic [3:0]  obs_sel = 4'h0, k;
   logic [15:0] obs_r, a, b, ret_addr_r;
   logic [31:0] p;
   flags_t      flags_r;
   pm_req_t     pm_r;
   logic [23:0] pm_rdata;
   int          cyc = 0, fail_count = 0, tests_run = 0;
   note_t       q[$]; // Expected results, oldest first.
   exec_unit u_exec_unit (.clk(clk), .rstn(rstn), .ce(1'b1), .req_valid(req_valid),
      .req(req), .ready_r(ready_r), .done_r(done_r), .skip_r(skip_r), .flags_r(flags_r),
      .irq_hold_r(irq_hold_r), .sleep_r(sleep_r), .idle_r(), .watchdog_timeout_flag_r(), .sleep_flag_r(),
      .wake(1'b0), .rep_load_r(), .rep_cnt_r(), .ret_addr_r(ret_addr_r), .pm_r(pm_r),
      .pm_rdata(pm_rdata),
      .obs_sel(obs_sel), .obs_r(obs_r));
   pm_model u_pm_model (.clk(clk), .pm(pm_r), .rdata(pm_rdata));
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Compares one value and reports a mismatch at once.
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      tests_run++;
      if (e !== s) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results();
      // A note still waiting means an operation never completed.
      if (q.size() != 0) fail_count++;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic req_t mk(op_t o, logic a, logic [3:0] s, t, d, logic [15:0] l);
      mk = '0;
      mk.op = o;
      mk.alt = a;
      mk.word_msb = 8'h01;
      mk.ra = s;
      mk.rb = t;
      mk.rd = d;
      mk.lit = l;
   endfunction
   // Issues one request once the unit is idle and notes what must follow.
   task automatic go(req_t x, int lat, logic [3:0] s, logic [15:0] v,
                     flags_t fm = '0, flags_t fv = '0);
      int n;
      n = 0;
      while ((q.size() != 0 || ready_r !== 1'b1) && n < 100) begin
         @(negedge clk);
         n++;
      end
      // A unit that never comes back idle counts as a mismatch.
      if (n >= 100) fail_count++;
      req = x;
      obs_sel = s;
      req_valid = 1;
      // The note is taken before the taking edge so the latency counts from it.
      q.push_back('{lat, cyc, v, fm, fv});
      @(negedge clk);
      req_valid = 0;
   endtask
   // Each completion is matched against the oldest note.
   always @(negedge clk) if (done_r === 1'b1 && q.size() != 0) begin
      chk("latency", q[0].lat, cyc - q[0].t0);
      @(negedge clk);
      chk("register", q[0].v, obs_r);
      chk("flags", q[0].fv, flags_r & q[0].fm);
      void'(q.pop_front());
   end
   initial begin
      #20000;
      fail_count++;
      results();
   end
   initial begin
      a = $urandom(32'hC492);
      b = $urandom | 1;
      k = $urandom;
      p = a * b;
      repeat (5) @(negedge clk);
      rstn = 1;
      go(mk(OP_MOVLIT, 0, 0, 0, 2, a), 1, 2, a);
      go(mk(OP_MOVLIT, 0, 0, 0, 3, b), 1, 3, b);
      go(mk(OP_MOVLIT, 0, 0, 0, 6, 16'h0005), 1, 6, 16'h0005);
      go(mk(OP_MUL, 0, 2, 3, 4, 0), 1, 5, p[31:16]);
      go(mk(OP_DIV, 0, 2, 3, 0, 0), 18, 0, a / b);
      // The bit number comes from the literal, not from a register.
      r = mk(OP_BIT_TEST_OP, 0, 2, 0, 0, k);
      r.use_lit = 1;
      go(r, 1, 2, a, 5'h10, {a[k], 4'h0});
      go(mk(OP_TBLWT, 1, 2, 0, 6, 0), 2, 2, a);
      go(mk(OP_TBLRD, 1, 6, 0, 7, 0), 2, 7, {8'h00, a[7:0]});
      r = mk(OP_CPSKIP, 0, 2, 2, 0, 0);
      r.two_next = 1;
      go(r, 3, 2, a);
      chk("skip", 1, skip_r);
      // Greater-than on equal operands must not skip.
      r.mode = 2'd1;
      go(r, 1, 2, a);
      chk("no skip", 0, skip_r);
      go(mk(OP_PUSH, 0, 2, 0, 0, 0), 1, 2, a);
      go(mk(OP_RET, 0, 0, 0, 0, 0), 3, 2, a);
      chk("return", a, ret_addr_r);
      r = mk(OP_RET, 0, 0, 0, 0, 0);
      r.short_ret = 1;
      go(r, 2, 2, a);
      go(mk(OP_HOLD, 0, 0, 0, 0, 16'h0005), 1, 2, a);
      chk("hold", 1, irq_hold_r);
      go(mk(OP_POWER_SAVE_OP, 0, 0, 0, 0, 0), 1, 2, a);
      chk("sleep", 1, sleep_r);
      r = mk(OP_BIT_TEST_THEN_SET_OP, 0, 3, 0, 0, k);
      r.use_lit = 1;
      go(r, 1, 3, b | (16'h0001 << k), 5'h10, {b[k], 4'h0});
      r = mk(OP_DIV, 0, 2, 3, 0, 0);
      r.word_msb = 8'h00;
      go(r, 1, 2, a);
      repeat (4) @(negedge clk);
      results();
   end
endmodule
